/* File: core/lss_slave_config_responder.sv */
// Contract
// RULE1: Frames carry eight bytes, command first, zero padding.
// RULE2: Requests use 7E5, responses use 7E4.
// RULE3: Slave holds four 32-bit identity values.
// RULE4: Configure only in configuration mode; master switches.
// RULE5: Global switch 04 selects wait or configuration.
// RULE6: Selective switch sends 40, 41, 42, 43.
// RULE7: Full identity match enters configuration, replies 44.
// RULE8: Node request 11 carries identifier 01 to 7F.
// RULE9: Node reply 11 with error 00 or 01.
// RULE10: Rate request 13, selector 00, table index.
// RULE11: Rate reply 13 with error 00 or 01.
// RULE12: Identity values travel least significant byte first.
// RULE13: Identity mismatch drops selection silently, no reply.
`timescale 1ns/1ps
`default_nettype none

module lss_slave_config_responder
   import lss_pkg::*;
#(
   parameter logic [31:0] VENDOR_ID = 32'h0000_0001, // Arbitrary value.
   parameter logic [31:0] PRODUCT_CODE = 32'h0000_0002, // Arbitrary value.
   parameter logic [31:0] REVISION_NO = 32'h0000_0003, // Arbitrary value.
   parameter logic [31:0] SERIAL_NO = 32'h0000_0004 // Arbitrary value.
)(
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic RX_VALID,
   input wire logic [10:0] RX_ID,
   input wire logic [3:0] RX_DLC,
   input wire logic [63:0] RX_DATA,
   output logic TX_VALID,
   output logic [10:0] TX_ID,
   output logic [3:0] TX_DLC,
   output logic [63:0] TX_DATA,
   output logic CONFIG_MODE,
   output logic [6:0] NODE_ID,
   output logic [3:0] RATE_INDEX
);

   // Selective switch progress, one-hot.
   typedef enum logic [3:0] {
      SEL_VENDOR = 4'h1,
      SEL_PRODUCT = 4'h2,
      SEL_REVISION = 4'h4,
      SEL_SERIAL = 4'h8
   } sel_t;

   sel_t sel_q, sel_d; // Next expected selective step.
   logic config_q, config_d; // High in configuration mode.
   logic [6:0] node_q, node_d; // Pending node identifier.
   logic [3:0] rate_q, rate_d; // Pending bit rate index.
   logic tx_valid_q, tx_valid_d; // Response strobe.
   logic [63:0] tx_data_q, tx_data_d; // Response payload.
   logic rate_ok; // Bit rate request is acceptable.
   logic take; // A well formed request arrived.
   logic [7:0] cs; // Command specifier of the request.
   logic [7:0] arg; // Byte 1 of the request.
   logic [7:0] idx; // Byte 2 of the request, the bit rate table index.
   logic [31:0] rx_word; // Identity value in bytes 1 to 4.

   // Extracts byte n of a frame; byte 0 sits in the low bits.
   function automatic logic [7:0] frame_byte(input logic [63:0] f, input int n);
      frame_byte = f[8*n +: 8];
   endfunction

   // Builds a response frame with command and one argument, rest zero.
   function automatic logic [63:0] reply(input logic [7:0] c, input logic [7:0] a);
      reply = {48'h0000_0000_0000, a, c}; // RULE1
   endfunction

   // Only eight byte frames on the request identifier are handled.
   assign take = RX_VALID && (RX_ID == ID_REQUEST) && (RX_DLC == 4'(FRAME_BYTES)); // RULE2 RULE1
   assign cs = frame_byte(RX_DATA, BYTE_CS);
   assign arg = frame_byte(RX_DATA, BYTE_ARG);
   assign idx = frame_byte(RX_DATA, BYTE_IDX);
   // Bytes 1 to 4, least significant byte first.
   assign rx_word = RX_DATA[8*BYTE_ARG +: 32]; // RULE12

   // Bit rate index decode.
   lss_rate_check u_rate (
      .selector(arg),
      .index(idx),
      .ok(rate_ok)
   );

   // Request interpreter: computes mode, selection, settings and reply.
   always_comb begin
      sel_d = sel_q;
      config_d = config_q;
      node_d = node_q;
      rate_d = rate_q;
      tx_valid_d = 1'b0;
      tx_data_d = tx_data_q;
      if (take) begin
         unique case (cs)
            CS_SWITCH_GLOBAL: begin
               // Any other mode byte is ignored.
               if (arg == MODE_WAIT) begin
                  config_d = 1'b0; // RULE5 RULE4
               end else if (arg == MODE_CONFIG) begin
                  config_d = 1'b1; // RULE5 RULE4
               end
            end
            CS_SEL_VENDOR: begin
               // A vendor frame always restarts the selection.
               sel_d = (rx_word == VENDOR_ID) ? SEL_PRODUCT : SEL_VENDOR; // RULE6 RULE3 RULE13
            end
            CS_SEL_PRODUCT: begin
               sel_d = (sel_q == SEL_PRODUCT && rx_word == PRODUCT_CODE) ?
                       SEL_REVISION : SEL_VENDOR; // RULE6 RULE3 RULE13
            end
            CS_SEL_REVISION: begin
               sel_d = (sel_q == SEL_REVISION && rx_word == REVISION_NO) ?
                       SEL_SERIAL : SEL_VENDOR; // RULE6 RULE3 RULE13
            end
            CS_SEL_SERIAL: begin
               sel_d = SEL_VENDOR;
               if (sel_q == SEL_SERIAL && rx_word == SERIAL_NO) begin
                  config_d = 1'b1; // RULE7
                  tx_valid_d = 1'b1; // RULE7
                  tx_data_d = reply(CS_SEL_CONFIRM, 8'h00); // RULE7
               end
            end
            CS_SET_NODE: begin
               // Ignored in wait mode.
               if (config_q) begin
                  tx_valid_d = 1'b1; // RULE4
                  if (arg >= NODE_MIN && arg <= NODE_MAX) begin
                     node_d = arg[6:0]; // RULE8
                     tx_data_d = reply(CS_SET_NODE, ERR_NONE); // RULE9
                  end else begin
                     tx_data_d = reply(CS_SET_NODE, ERR_INVALID); // RULE9
                  end
               end
            end
            CS_SET_RATE: begin
               if (config_q) begin
                  tx_valid_d = 1'b1; // RULE4
                  if (rate_ok) begin
                     // Only indices up to eight pass the check, so four bits hold all.
                     rate_d = idx[3:0]; // RULE10
                     tx_data_d = reply(CS_SET_RATE, ERR_NONE); // RULE11
                  end else begin
                     tx_data_d = reply(CS_SET_RATE, ERR_INVALID); // RULE11
                  end
               end
            end
            default: begin
               // Other services are not handled here.
            end
         endcase
      end
   end

   // State registers.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         sel_q <= SEL_VENDOR;
         config_q <= 1'b0;
         node_q <= NODE_RESET;
         rate_q <= RATE_RESET;
         tx_valid_q <= 1'b0;
         tx_data_q <= 64'h0000_0000_0000_0000;
      end else begin
         sel_q <= sel_d;
         config_q <= config_d;
         node_q <= node_d;
         rate_q <= rate_d;
         tx_valid_q <= tx_valid_d;
         tx_data_q <= tx_data_d;
      end
   end

   // Outputs come straight from flip-flops or are constants.
   assign TX_VALID = tx_valid_q;
   assign TX_ID = ID_RESPONSE; // RULE2
   assign TX_DLC = 4'(FRAME_BYTES); // RULE1
   assign TX_DATA = tx_data_q;
   assign CONFIG_MODE = config_q;
   assign NODE_ID = node_q;
   assign RATE_INDEX = rate_q;

   // Named sequences for the selective switch.
   sequence s_sel_frame(logic [7:0] c, logic [31:0] v);
      take && cs == c && rx_word == v;
   endsequence

   sequence s_sel_last;
      s_sel_frame(CS_SEL_SERIAL, SERIAL_NO) && sel_q == SEL_SERIAL;
   endsequence

   a_global_wait: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE5
      take && cs == CS_SWITCH_GLOBAL && arg == MODE_WAIT |=> !CONFIG_MODE)
      else $error("Global switch to wait ignored.");

   a_global_config: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE5
      take && cs == CS_SWITCH_GLOBAL && arg == MODE_CONFIG |=> CONFIG_MODE)
      else $error("Global switch to configuration ignored.");

   a_sel_confirm: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE7
      s_sel_last |=> CONFIG_MODE && TX_VALID && TX_DATA == 64'h0000_0000_0000_0044)
      else $error("Selective match not confirmed.");

   a_sel_mismatch: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE13
      take && cs == CS_SEL_SERIAL && rx_word != SERIAL_NO |=> !TX_VALID)
      else $error("Reply after identity mismatch.");

   a_sel_order: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE6
      s_sel_frame(CS_SEL_VENDOR, VENDOR_ID) |=> sel_q == SEL_PRODUCT)
      else $error("Vendor match did not advance selection.");

   a_node_bad: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE9
      take && config_q && cs == CS_SET_NODE && (arg == 8'h00 || arg > NODE_MAX)
      |=> TX_VALID && TX_DATA[15:8] == ERR_INVALID && $stable(NODE_ID))
      else $error("Invalid node identifier accepted.");

   a_node_good: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE8
      take && config_q && cs == CS_SET_NODE && arg >= NODE_MIN && arg <= NODE_MAX
      |=> TX_VALID && TX_DATA[15:0] == 16'h0011 && NODE_ID == $past(arg[6:0]))
      else $error("Valid node identifier not taken.");

   a_wait_silent: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE4
      take && !config_q && (cs == CS_SET_NODE || cs == CS_SET_RATE) |=> !TX_VALID)
      else $error("Configuration answered in wait mode.");

   a_rate_reply: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE11
      take && config_q && cs == CS_SET_RATE
      |=> TX_VALID && TX_DATA[7:0] == CS_SET_RATE
         && TX_DATA[15:8] == ($past(rate_ok) ? ERR_NONE : ERR_INVALID))
      else $error("Bit rate reply wrong.");

   a_frame_pad: assert property (@(posedge MCLK) disable iff (!RST_N) // RULE1
      TX_VALID |-> TX_DATA[63:16] == 48'h0000_0000_0000)
      else $error("Response padding not zero.");

endmodule

`default_nettype wire

/* File: core/lss_pkg.sv */
package lss_pkg;

   // Frame length and CAN identifiers for the layer setting exchange.
   localparam int FRAME_BYTES = 8;
   localparam logic [10:0] ID_REQUEST = 11'h7E5;
   localparam logic [10:0] ID_RESPONSE = 11'h7E4;

   // Command specifiers.
   localparam logic [7:0] CS_SWITCH_GLOBAL = 8'h04;
   localparam logic [7:0] CS_SEL_VENDOR = 8'h40;
   localparam logic [7:0] CS_SEL_PRODUCT = 8'h41;
   localparam logic [7:0] CS_SEL_REVISION = 8'h42;
   localparam logic [7:0] CS_SEL_SERIAL = 8'h43;
   localparam logic [7:0] CS_SEL_CONFIRM = 8'h44;
   localparam logic [7:0] CS_SET_NODE = 8'h11;
   localparam logic [7:0] CS_SET_RATE = 8'h13;

   // Mode byte values of the global switch.
   localparam logic [7:0] MODE_WAIT = 8'h00;
   localparam logic [7:0] MODE_CONFIG = 8'h01;

   // Error codes of confirmations.
   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_INVALID = 8'h01;

   // Node identifier limits and reset value.
   localparam logic [7:0] NODE_MIN = 8'h01;
   localparam logic [7:0] NODE_MAX = 8'h7F;
   localparam logic [6:0] NODE_RESET = 7'h7F;

   // Bit rate table selector and reset index.
   localparam logic [7:0] RATE_TABLE = 8'h00;
   localparam logic [3:0] RATE_RESET = 4'h0;

   // Byte positions inside a frame.
   localparam int BYTE_CS = 0;
   localparam int BYTE_ARG = 1;
   localparam int BYTE_IDX = 2;

endpackage

/* File: core/lss_rate_check.sv */
`timescale 1ns/1ps
`default_nettype none

// Checks a bit rate request: selector must be the standard table and the
// index one of the supported entries (0, 2, 3, 4, 6, 7 or 8).
module lss_rate_check
   import lss_pkg::*;
(
   input wire logic [7:0] selector,
   input wire logic [7:0] index,
   output logic ok
);

   // Combinational decode of the supported table entries.
   always_comb begin
      unique case (index)
         8'h00, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08: ok = (selector == RATE_TABLE);
         default: ok = 1'b0;
      endcase
   end

endmodule

`default_nettype wire

/* File: testbench/lss_master_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Behavioural bus master that puts one request frame per call on the slave.
module lss_master_model
   import lss_pkg::*;
(
   input wire logic clk,
   output logic rx_valid,
   output logic [10:0] rx_id,
   output logic [3:0] rx_dlc,
   output logic [63:0] rx_data
);
   // The bus is idle at time zero.
   initial begin
      rx_valid = 1'b0;
      rx_id = ID_REQUEST;
      rx_dlc = 4'h8;
      rx_data = 64'h0;
   end

   // Sends one frame for a single cycle; identity values go low byte first.
   task automatic send(input logic [7:0] cs, input logic [31:0] arg);
      send_raw(ID_REQUEST, 4'(FRAME_BYTES), cs, arg);
   endtask

   // Sends one frame with any identifier and length, so the filter can be tried.
   task automatic send_raw(input logic [10:0] id, input logic [3:0] dlc,
      input logic [7:0] cs, input logic [31:0] arg);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_id <= id;
      rx_dlc <= dlc;
      rx_data <= {24'h0, arg, cs};
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_data <= ~{24'h0, arg, cs}; // Released data no longer shows the frame.
   endtask
endmodule

`default_nettype wire

/* File: testbench/lss_slave_config_responder_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module lss_slave_config_responder_tb_top
   import lss_pkg::*;
();
   localparam logic [31:0] VID = 32'h1122_3344; // Arbitrary value.
   localparam logic [31:0] PID = 32'hA5B6_C7D8; // Arbitrary value.
   localparam logic [31:0] RID = 32'h0102_0304; // Arbitrary value.
   localparam logic [31:0] SID = 32'hCAFE_0001; // Arbitrary value.
   logic mclk, rst_n, rx_valid, tx_valid, config_mode;
   logic [10:0] rx_id, tx_id;
   logic [3:0] rx_dlc, tx_dlc, rate_index;
   logic [63:0] rx_data, tx_data;
   logic [6:0] node_id;
   int n_fail = 0; // Mismatches seen.
   int total_checks = 0; // Comparisons made.

   // The master model drives every request input.
   lss_master_model master (.clk(mclk), .rx_valid(rx_valid), .rx_id(rx_id),
      .rx_dlc(rx_dlc), .rx_data(rx_data));

   lss_slave_config_responder #(.VENDOR_ID(VID), .PRODUCT_CODE(PID), .REVISION_NO(RID),
      .SERIAL_NO(SID)) dut (.MCLK(mclk), .RST_N(rst_n), .RX_VALID(rx_valid), .RX_ID(rx_id),
      .RX_DLC(rx_dlc), .RX_DATA(rx_data), .TX_VALID(tx_valid), .TX_ID(tx_id),
      .TX_DLC(tx_dlc), .TX_DATA(tx_data), .CONFIG_MODE(config_mode),
      .NODE_ID(node_id), .RATE_INDEX(rate_index));

   // The clock toggles every half period of 12.5 ns.
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // Compares one value and reports a mismatch at once.
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Sends a request and judges the reply pulse and, when one is due, its frame.
   task automatic req(input logic [7:0] cs, input logic [31:0] arg, input logic rep,
      input logic [7:0] rcs, input logic [7:0] err);
      master.send(cs, arg);
      #1;
      chk("reply pulse", {63'h0, rep}, {63'h0, tx_valid});
      if (rep) begin
         chk("reply data", {48'h0, err, rcs}, tx_data);
         chk("reply id", {53'h0, ID_RESPONSE}, {53'h0, tx_id});
         chk("reply length", 64'h8, {60'h0, tx_dlc});
         @(posedge mclk);
         #1;
         chk("pulse end", 64'h0, {63'h0, tx_valid});
      end
   endtask

   // Wait mode refuses configuration requests.
   task automatic t_wait();
      chk("mode", 64'h0, {63'h0, config_mode});
      req(CS_SET_NODE, 32'h5, 1'b0, 8'h0, 8'h0);
      chk("node", 64'h7F, {57'h0, node_id});
      $display("test wait done");
   endtask

   // Global switch enters configuration mode; a bad mode byte changes nothing.
   task automatic t_global();
      req(CS_SWITCH_GLOBAL, {24'h0, MODE_CONFIG}, 1'b0, 8'h0, 8'h0);
      chk("mode", 64'h1, {63'h0, config_mode});
      req(CS_SWITCH_GLOBAL, 32'h2, 1'b0, 8'h0, 8'h0);
      chk("mode", 64'h1, {63'h0, config_mode});
      $display("test global done");
   endtask

   // Node identifiers at and beyond both limits.
   task automatic t_node();
      logic [7:0] vals [5] = '{8'h00, 8'h01, 8'h7F, 8'h80, 8'h05};
      logic [6:0] exp = 7'h7F;
      logic ok;
      foreach (vals[i]) begin
         ok = (vals[i] >= NODE_MIN) && (vals[i] <= NODE_MAX);
         if (ok) begin
            exp = vals[i][6:0];
         end
         req(CS_SET_NODE, {24'h0, vals[i]}, 1'b1, CS_SET_NODE, {7'h0, !ok});
         chk("node", {57'h0, exp}, {57'h0, node_id});
      end
      $display("test node done");
   endtask

   // Every table index from 0 to 9, supported and unsupported.
   task automatic t_rate();
      logic [3:0] exp = RATE_RESET;
      logic ok;
      for (int i = 0; i < 10; i++) begin
         ok = (i inside {0, 2, 3, 4, 6, 7, 8});
         if (ok) begin
            exp = 4'(i);
         end
         req(CS_SET_RATE, {16'h0, 8'(i), RATE_TABLE}, 1'b1, CS_SET_RATE, {7'h0, !ok});
         chk("rate", {60'h0, exp}, {60'h0, rate_index});
      end
      // A supported index under a foreign table selector is refused.
      req(CS_SET_RATE, {16'h0, 8'h04, 8'h01}, 1'b1, CS_SET_RATE, ERR_INVALID);
      chk("rate", {60'h0, exp}, {60'h0, rate_index});
      $display("test rate done");
   endtask

   // Frames on the response identifier or with seven bytes are not requests.
   task automatic t_filter();
      master.send_raw(ID_RESPONSE, 4'(FRAME_BYTES), CS_SET_NODE, 32'h9);
      #1;
      chk("reply pulse", 64'h0, {63'h0, tx_valid});
      master.send_raw(ID_REQUEST, 4'(FRAME_BYTES - 1), CS_SET_NODE, 32'h9);
      #1;
      chk("reply pulse", 64'h0, {63'h0, tx_valid});
      chk("node", 64'h05, {57'h0, node_id});
      $display("test filter done");
   endtask

   // A wrong serial aborts silently; the full address then selects.
   task automatic t_select();
      req(CS_SWITCH_GLOBAL, {24'h0, MODE_WAIT}, 1'b0, 8'h0, 8'h0);
      chk("mode", 64'h0, {63'h0, config_mode});
      req(CS_SEL_VENDOR, VID, 1'b0, 8'h0, 8'h0);
      req(CS_SEL_PRODUCT, PID, 1'b0, 8'h0, 8'h0);
      req(CS_SEL_REVISION, RID, 1'b0, 8'h0, 8'h0);
      req(CS_SEL_SERIAL, ~SID, 1'b0, 8'h0, 8'h0);
      chk("mode", 64'h0, {63'h0, config_mode});
      req(CS_SEL_VENDOR, VID, 1'b0, 8'h0, 8'h0);
      req(CS_SEL_PRODUCT, PID, 1'b0, 8'h0, 8'h0);
      req(CS_SEL_REVISION, RID, 1'b0, 8'h0, 8'h0);
      req(CS_SEL_SERIAL, SID, 1'b1, CS_SEL_CONFIRM, 8'h0);
      chk("mode", 64'h1, {63'h0, config_mode});
      $display("test select done");
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Cuts a hang short well after the tests should have ended.
   initial begin
      #(25 * 4000);
      n_fail++;
      close_out();
   end

   // Holds reset for six cycles, then runs the scenarios in order.
   initial begin
      rst_n = 1'b0;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      t_wait();
      t_global();
      t_node();
      t_rate();
      t_filter();
      t_select();
      close_out();
   end
endmodule

`default_nettype wire
